/* hw/ctcc_map.vh */
`ifndef CTCC_MAP_VH
`define CTCC_MAP_VH

// Register addresses on the host register port
`define CTCC_ADDR_W 6
`define CTCC_ADDR_CFG 6'h13
`define CTCC_ADDR_OFS_HI 6'h14
`define CTCC_ADDR_OFS_LO 6'h15
`define CTCC_ADDR_GAIN_HI 6'h16
`define CTCC_ADDR_GAIN_LO 6'h17

// Register width and reset values
`define CTCC_DATA_W 16
`define CTCC_RST_CFG 16'h0000
`define CTCC_RST_OFS_HI 16'h0000
`define CTCC_RST_OFS_LO 16'h0000
`define CTCC_RST_GAIN_HI 16'h8000
`define CTCC_RST_GAIN_LO 16'h0000

// Writable bit masks; cleared bits are reserved and read as zero
`define CTCC_MASK_CFG 16'hFFC7
`define CTCC_MASK_FULL 16'hFFFF
`define CTCC_MASK_LO 16'hFF00

// Configuration register fields
`define CTCC_PHASE_MSB 15
`define CTCC_PHASE_LSB 6
`define CTCC_PHASE_W 10
`define CTCC_DCOFF_BIT 2
`define CTCC_MUX_MSB 1
`define CTCC_MUX_LSB 0
`define CTCC_MUX_W 2

// Low calibration registers hold the low byte of the word in 15:8
`define CTCC_LO_MSB 15
`define CTCC_LO_LSB 8
`define CTCC_CAL_W 24

// Input selection codes
`define CTCC_MUX_OWN 2'h0
`define CTCC_MUX_SHORT 2'h1
`define CTCC_MUX_TEST_POS 2'h2
`define CTCC_MUX_TEST_NEG 2'h3

// Global DC filter setting; zero means the filter is off globally
`define CTCC_DCSET_W 4
`define CTCC_DCSET_OFF 4'h0

`endif

/* hw/ctcc_reg_cell.v */
`include "ctcc_map.vh"

module ctcc_reg_cell #(
  parameter [`CTCC_DATA_W-1:0] RST_VAL = `CTCC_RST_CFG,
  parameter [`CTCC_DATA_W-1:0] WR_MASK = `CTCC_MASK_FULL
) (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_wr,
  input wire [`CTCC_DATA_W-1:0] i_wdata,
  output wire [`CTCC_DATA_W-1:0] o_q
);

  reg [`CTCC_DATA_W-1:0] q_r;
  wire [`CTCC_DATA_W-1:0] q_nxt;

  assign q_nxt = i_wr ? (i_wdata & WR_MASK) : q_r;

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_r <= RST_VAL & WR_MASK;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule // ctcc_reg_cell

/* hw/ctcc_regs.v */
// Operation
// - Phase delay, signed, bits 15:6, reset zero
// - Bit 2 disables DC filter locally
// - Bits 1:0 select converter input source
// - Config bits 5:3 always read zero
// - Offset high holds offset bits 23:8
// - Offset low byte in 15:8, rest zero
// - Gain high holds bits 23:8, reset 8000h
// - Gain low byte in 15:8, rest zero
`include "ctcc_map.vh"

module ctcc_regs (
  input wire i_ref_clk,
  input wire i_nrst,
  input wire [`CTCC_ADDR_W-1:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [`CTCC_DATA_W-1:0] i_reg_wdata,
  input wire [`CTCC_DCSET_W-1:0] i_global_dc_filter_setting,
  output reg [`CTCC_DATA_W-1:0] o_reg_rdata,
  output reg o_reg_rvalid,
  output reg o_reg_err,
  output wire [`CTCC_DATA_W-1:0] o_chan_b_config,
  output wire [`CTCC_PHASE_W-1:0] o_chan_b_phase_delay,
  output wire o_chan_b_dc_filter_off,
  output wire [`CTCC_MUX_W-1:0] o_chan_b_input_select,
  output wire [`CTCC_CAL_W-1:0] o_chan_b_offset,
  output wire [`CTCC_CAL_W-1:0] o_chan_b_gain,
  output reg [`CTCC_DCSET_W-1:0] o_chan_b_dc_filter_coef,
  output reg o_chan_b_dc_filter_active,
  output reg o_chan_b_sel_own_pins,
  output reg o_chan_b_sel_shorted,
  output reg o_chan_b_sel_test_pos,
  output reg o_chan_b_sel_test_neg,
  output reg o_chan_b_phase_updated,
  output reg o_chan_b_cal_updated
);

  // Address match, used for every register select
  function addr_is;
    input [`CTCC_ADDR_W-1:0] addr;
    input [`CTCC_ADDR_W-1:0] ref_addr;
    begin
      addr_is = (addr == ref_addr);
    end
  endfunction

  // Place a low calibration byte under its high word
  function [`CTCC_CAL_W-1:0] join_cal;
    input [`CTCC_DATA_W-1:0] hi;
    input [`CTCC_DATA_W-1:0] lo;
    begin
      join_cal = {hi, lo[`CTCC_LO_MSB:`CTCC_LO_LSB]};
    end
  endfunction

  // Phase field of a configuration word
  function [`CTCC_PHASE_W-1:0] phase_of;
    input [`CTCC_DATA_W-1:0] word;
    begin
      phase_of = word[`CTCC_PHASE_MSB:`CTCC_PHASE_LSB];
    end
  endfunction

  // Input selection field of a configuration word
  function [`CTCC_MUX_W-1:0] mux_of;
    input [`CTCC_DATA_W-1:0] word;
    begin
      mux_of = word[`CTCC_MUX_MSB:`CTCC_MUX_LSB];
    end
  endfunction

  wire sel_cfg;
  wire sel_ofs_hi;
  wire sel_ofs_lo;
  wire sel_gain_hi;
  wire sel_gain_lo;
  wire sel_any;
  wire wr_cfg;
  wire wr_ofs_hi;
  wire wr_ofs_lo;
  wire wr_gain_hi;
  wire wr_gain_lo;
  wire [`CTCC_DATA_W-1:0] cfg_q;
  wire [`CTCC_DATA_W-1:0] ofs_hi_q;
  wire [`CTCC_DATA_W-1:0] ofs_lo_q;
  wire [`CTCC_DATA_W-1:0] gain_hi_q;
  wire [`CTCC_DATA_W-1:0] gain_lo_q;
  reg [`CTCC_DATA_W-1:0] rd_mux;
  reg [`CTCC_DATA_W-1:0] rdata_nxt;
  reg rvalid_nxt;
  reg err_nxt;
  reg [`CTCC_DCSET_W-1:0] coef_nxt;
  reg active_nxt;
  reg own_nxt;
  reg short_nxt;
  reg tpos_nxt;
  reg tneg_nxt;
  reg phase_upd_nxt;
  reg cal_upd_nxt;

  assign sel_cfg = addr_is(i_reg_addr, `CTCC_ADDR_CFG);
  assign sel_ofs_hi = addr_is(i_reg_addr, `CTCC_ADDR_OFS_HI);
  assign sel_ofs_lo = addr_is(i_reg_addr, `CTCC_ADDR_OFS_LO);
  assign sel_gain_hi = addr_is(i_reg_addr, `CTCC_ADDR_GAIN_HI);
  assign sel_gain_lo = addr_is(i_reg_addr, `CTCC_ADDR_GAIN_LO);
  assign sel_any = sel_cfg | sel_ofs_hi | sel_ofs_lo | sel_gain_hi |
    sel_gain_lo;

  assign wr_cfg = i_reg_wr & sel_cfg;
  assign wr_ofs_hi = i_reg_wr & sel_ofs_hi;
  assign wr_ofs_lo = i_reg_wr & sel_ofs_lo;
  assign wr_gain_hi = i_reg_wr & sel_gain_hi;
  assign wr_gain_lo = i_reg_wr & sel_gain_lo;

  ctcc_reg_cell #(
    .RST_VAL(`CTCC_RST_CFG),
    .WR_MASK(`CTCC_MASK_CFG)
  ) u_cfg (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_cfg),
    .i_wdata(i_reg_wdata),
    .o_q(cfg_q)
  );

  ctcc_reg_cell #(
    .RST_VAL(`CTCC_RST_OFS_HI),
    .WR_MASK(`CTCC_MASK_FULL)
  ) u_ofs_hi (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_ofs_hi),
    .i_wdata(i_reg_wdata),
    .o_q(ofs_hi_q)
  );

  ctcc_reg_cell #(
    .RST_VAL(`CTCC_RST_OFS_LO),
    .WR_MASK(`CTCC_MASK_LO)
  ) u_ofs_lo (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_ofs_lo),
    .i_wdata(i_reg_wdata),
    .o_q(ofs_lo_q)
  );

  ctcc_reg_cell #(
    .RST_VAL(`CTCC_RST_GAIN_HI),
    .WR_MASK(`CTCC_MASK_FULL)
  ) u_gain_hi (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_gain_hi),
    .i_wdata(i_reg_wdata),
    .o_q(gain_hi_q)
  );

  ctcc_reg_cell #(
    .RST_VAL(`CTCC_RST_GAIN_LO),
    .WR_MASK(`CTCC_MASK_LO)
  ) u_gain_lo (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_gain_lo),
    .i_wdata(i_reg_wdata),
    .o_q(gain_lo_q)
  );

  // Field views straight from the register flops
  assign o_chan_b_config = cfg_q;
  assign o_chan_b_phase_delay = phase_of(cfg_q);
  assign o_chan_b_dc_filter_off = cfg_q[`CTCC_DCOFF_BIT];
  assign o_chan_b_input_select = mux_of(cfg_q);
  assign o_chan_b_offset = join_cal(ofs_hi_q, ofs_lo_q);
  assign o_chan_b_gain = join_cal(gain_hi_q, gain_lo_q);

  // Read mux sees the values before any same-cycle write
  always @* begin
    rd_mux = {`CTCC_DATA_W{1'b0}};
    case (1'b1)
      sel_cfg: begin
        rd_mux = cfg_q;
      end
      sel_ofs_hi: begin
        rd_mux = ofs_hi_q;
      end
      sel_ofs_lo: begin
        rd_mux = ofs_lo_q;
      end
      sel_gain_hi: begin
        rd_mux = gain_hi_q;
      end
      sel_gain_lo: begin
        rd_mux = gain_lo_q;
      end
      default: begin
        rd_mux = {`CTCC_DATA_W{1'b0}};
      end
    endcase
  end

  // Read answer one cycle after the request; unmapped answers zero
  always @* begin
    rdata_nxt = o_reg_rdata;
    rvalid_nxt = 1'b0;
    err_nxt = 1'b0;
    if (i_reg_rd) begin
      rdata_nxt = rd_mux;
      rvalid_nxt = 1'b1;
    end
    if ((i_reg_rd | i_reg_wr) & ~sel_any) begin
      err_nxt = 1'b1;
    end
  end

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= {`CTCC_DATA_W{1'b0}};
      o_reg_rvalid <= 1'b0;
      o_reg_err <= 1'b0;
    end else begin
      o_reg_rdata <= rdata_nxt;
      o_reg_rvalid <= rvalid_nxt;
      o_reg_err <= err_nxt;
    end
  end

  // Effective filter setting and one-hot input routing
  always @* begin
    if (cfg_q[`CTCC_DCOFF_BIT]) begin
      coef_nxt = `CTCC_DCSET_OFF;
    end else begin
      coef_nxt = i_global_dc_filter_setting;
    end
    active_nxt = (coef_nxt != `CTCC_DCSET_OFF);
    own_nxt = 1'b0;
    short_nxt = 1'b0;
    tpos_nxt = 1'b0;
    tneg_nxt = 1'b0;
    case (mux_of(cfg_q))
      `CTCC_MUX_OWN: begin
        own_nxt = 1'b1;
      end
      `CTCC_MUX_SHORT: begin
        short_nxt = 1'b1;
      end
      `CTCC_MUX_TEST_POS: begin
        tpos_nxt = 1'b1;
      end
      `CTCC_MUX_TEST_NEG: begin
        tneg_nxt = 1'b1;
      end
      default: begin
        own_nxt = 1'b1;
      end
    endcase
  end

  // Update strobes let the datapath reload phase and calibration
  always @* begin
    // Same-phase rewrite must not restart the phase aligner
    phase_upd_nxt = wr_cfg &
      (phase_of(i_reg_wdata) != phase_of(cfg_q));
    cal_upd_nxt = wr_ofs_hi | wr_ofs_lo | wr_gain_hi | wr_gain_lo;
  end

  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_chan_b_dc_filter_coef <= `CTCC_DCSET_OFF;
      o_chan_b_dc_filter_active <= 1'b0;
      o_chan_b_sel_own_pins <= 1'b1;
      o_chan_b_sel_shorted <= 1'b0;
      o_chan_b_sel_test_pos <= 1'b0;
      o_chan_b_sel_test_neg <= 1'b0;
      o_chan_b_phase_updated <= 1'b0;
      o_chan_b_cal_updated <= 1'b0;
    end else begin
      o_chan_b_dc_filter_coef <= coef_nxt;
      o_chan_b_dc_filter_active <= active_nxt;
      o_chan_b_sel_own_pins <= own_nxt;
      o_chan_b_sel_shorted <= short_nxt;
      o_chan_b_sel_test_pos <= tpos_nxt;
      o_chan_b_sel_test_neg <= tneg_nxt;
      o_chan_b_phase_updated <= phase_upd_nxt;
      o_chan_b_cal_updated <= cal_upd_nxt;
    end
  end

endmodule // ctcc_regs

/* verif/ctcc_host_model.sv */
module ctcc_host (
  input logic i_ref_clk,
  input logic [15:0] i_rdata,
  input logic i_rvalid,
  input logic i_err,
  output logic [5:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_addr = 6'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // Released lines show the inverse, never the stale value
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge i_ref_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task rd(input logic [5:0] a, output logic [15:0] d, output logic v,
          output logic e);
    @(negedge i_ref_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_ref_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rvalid;
    e = i_err;
  endtask
endmodule // ctcc_host

/* verif/ctcc_regs_properties.sv */
module ctcc_regs_props (
  input logic i_ref_clk,
  input logic i_nrst,
  input logic [5:0] i_reg_addr,
  input logic i_reg_wr,
  input logic i_reg_rd,
  input logic [15:0] i_reg_wdata,
  input logic [15:0] o_reg_rdata,
  input logic o_reg_rvalid,
  input logic [15:0] o_chan_b_config,
  input logic [9:0] o_chan_b_phase_delay,
  input logic o_chan_b_dc_filter_off,
  input logic [1:0] o_chan_b_input_select,
  input logic [23:0] o_chan_b_offset,
  input logic [23:0] o_chan_b_gain,
  input logic [3:0] o_chan_b_dc_filter_coef,
  input logic o_chan_b_phase_updated,
  input logic o_chan_b_cal_updated
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic wc;
  logic cfg_rd;
  logic lo_rd;
  logic cal_wr;
  logic phase_chg;
  assign wc = i_reg_wr && i_reg_addr == 6'h13;
  assign cfg_rd = i_reg_rd && i_reg_addr == 6'h13;
  assign lo_rd = i_reg_rd && (i_reg_addr == 6'h15 || i_reg_addr == 6'h17);
  assign cal_wr = i_reg_wr && i_reg_addr >= 6'h14 && i_reg_addr <= 6'h17;
  assign phase_chg = wc && i_reg_wdata[15:6] != o_chan_b_phase_delay;
  a_cfg_rsvd_keep: assert property (wc |=>
    o_chan_b_config == ($past(i_reg_wdata) & 16'hFFC7)) else $error("cfg");
  a_phase_delay_set: assert property (wc |=>
    o_chan_b_phase_delay == $past(i_reg_wdata[15:6])) else $error("phase");
  a_dc_off_set: assert property (wc |=>
    o_chan_b_dc_filter_off == $past(i_reg_wdata[2])) else $error("dc off");
  a_mux_sel_set: assert property (wc |=>
    o_chan_b_input_select == $past(i_reg_wdata[1:0])) else $error("mux");
  a_ofs_high_set: assert property (i_reg_wr && i_reg_addr == 6'h14 |=>
    o_chan_b_offset[23:8] == $past(i_reg_wdata)) else $error("ofs hi");
  a_ofs_low_set: assert property (i_reg_wr && i_reg_addr == 6'h15 |=>
    o_chan_b_offset[7:0] == $past(i_reg_wdata[15:8])) else $error("ofs lo");
  a_gain_high_set: assert property (i_reg_wr && i_reg_addr == 6'h16 |=>
    o_chan_b_gain[23:8] == $past(i_reg_wdata)) else $error("gain hi");
  a_gain_low_set: assert property (i_reg_wr && i_reg_addr == 6'h17 |=>
    o_chan_b_gain[7:0] == $past(i_reg_wdata[15:8])) else $error("gain lo");
  a_low_read_zero: assert property (lo_rd |=>
    o_reg_rvalid && o_reg_rdata[7:0] == 8'h00) else $error("lo byte");
  a_cfg_rsvd_read: assert property (cfg_rd |=>
    o_reg_rvalid && o_reg_rdata[5:3] == 3'h0) else $error("cfg rsvd");
  a_dc_coef_forced: assert property (o_chan_b_dc_filter_off |=>
    o_chan_b_dc_filter_coef == 4'h0) else $error("dc coef");
  a_phase_upd_set: assert property (phase_chg |=>
    o_chan_b_phase_updated) else $error("phase upd");
  a_phase_upd_quiet: assert property (!phase_chg |=>
    !o_chan_b_phase_updated) else $error("phase quiet");
  a_cal_upd_set: assert property (cal_wr |=>
    o_chan_b_cal_updated) else $error("cal upd");
  a_cal_upd_quiet: assert property (!cal_wr |=>
    !o_chan_b_cal_updated) else $error("cal quiet");
  c_cfg_wr: cover property (wc);
  c_gain_rd: cover property (i_reg_rd && i_reg_addr == 6'h17);
  c_cal_wr: cover property (i_reg_wr && i_reg_addr == 6'h14);
  c_phase_upd: cover property (o_chan_b_phase_updated);
endmodule // ctcc_regs_props

bind ctcc_regs ctcc_regs_props u_props (
  .i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst),
  .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid),
  .o_chan_b_config(o_chan_b_config),
  .o_chan_b_phase_delay(o_chan_b_phase_delay),
  .o_chan_b_dc_filter_off(o_chan_b_dc_filter_off),
  .o_chan_b_input_select(o_chan_b_input_select),
  .o_chan_b_offset(o_chan_b_offset),
  .o_chan_b_gain(o_chan_b_gain),
  .o_chan_b_dc_filter_coef(o_chan_b_dc_filter_coef),
  .o_chan_b_phase_updated(o_chan_b_phase_updated),
  .o_chan_b_cal_updated(o_chan_b_cal_updated)
);

/* verif/ctcc_regs_tb_top.sv */
module ctcc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] addr, a;
  logic wr, rd, rv, er, v, e;
  logic [15:0] wd, rdat, d, cfg;
  logic [15:0] m [0:4];
  logic [3:0] glb = 4'h0;
  logic [3:0] coef, sel;
  logic act;
  logic [23:0] ofs, gn;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  ctcc_host host (.i_ref_clk(clk), .i_rdata(rdat), .i_rvalid(rv),
    .i_err(er), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wd));
  ctcc_regs dut (.i_ref_clk(clk), .i_nrst(nrst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd),
    .i_global_dc_filter_setting(glb), .o_reg_rdata(rdat),
    .o_reg_rvalid(rv), .o_reg_err(er), .o_chan_b_config(cfg),
    .o_chan_b_phase_delay(), .o_chan_b_dc_filter_off(),
    .o_chan_b_input_select(), .o_chan_b_offset(ofs), .o_chan_b_gain(gn),
    .o_chan_b_dc_filter_coef(coef), .o_chan_b_dc_filter_active(act),
    .o_chan_b_sel_own_pins(sel[0]), .o_chan_b_sel_shorted(sel[1]),
    .o_chan_b_sel_test_pos(sel[2]), .o_chan_b_sel_test_neg(sel[3]),
    .o_chan_b_phase_updated(), .o_chan_b_cal_updated());
  function logic [15:0] msk(input int i);
    return i == 0 ? 16'hFFC7 : (i[0] ? 16'hFFFF : 16'hFF00);
  endfunction
  task chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize;
    end
  end
  task check_reset;
    for (int i = 0; i < 5; i++) begin
      m[i] = i == 3 ? 16'h8000 : 16'h0000;
      host.rd(6'(6'h13 + i), d, v, e);
      chk({v, e, d}, {2'h2, m[i]});
    end
    chk(ofs, 24'h000000);
    chk(gn, 24'h800000);
    chk(sel, 4'h1);
    chk({act, coef}, {glb != 4'h0, glb});
  endtask
  initial begin
    void'($urandom(32'h639c49b2));
    repeat (16) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    check_reset;
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      @(negedge clk) glb = 4'($urandom);
      a = 6'(i < 5 ? 6'h13 + i : 6'h13 + $urandom % 5);
      d = i < 5 ? 16'hFFFF : 16'($urandom);
      host.wr(a, d);
      m[a - 6'h13] = d & msk(a - 6'h13);
      host.rd(a, d, v, e);
      chk({v, e, d}, {2'h2, m[a - 6'h13]});
      chk(ofs, {m[1], m[2][15:8]});
      chk(gn, {m[3], m[4][15:8]});
      chk(sel, 4'h1 << m[0][1:0]);
      chk(coef, m[0][2] ? 4'h0 : glb);
      chk(act, !m[0][2] && glb != 4'h0);
      chk(cfg[15:6], m[0][15:6]);
    end
    $display("test random done");
    host.wr(6'h12, 16'hFFFF);
    host.rd(6'h20, d, v, e);
    chk({v, e, d}, {2'h3, 16'h0000});
    host.rd(6'h14, d, v, e);
    chk(d, m[1]);
    $display("test unmapped done");
    @(negedge clk) nrst = 1'b0;
    repeat (4) @(negedge clk);
    chk({rv, er, rdat}, {2'h0, 16'h0000});
    nrst = 1'b1;
    check_reset;
    $display("test reset again done");
    summarize;
  end
endmodule // ctcc_regs_tb_top
